// [logic/scc_channel_ctrl.sv]
// one channel of serial video control and status, reached over AHB-Lite
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module scc_channel_ctrl import scc_pkg::*; #(
   parameter int CNT_W = 16,
   parameter int CAP_AW = 6
) (
   input wire logic sys_clk, // 125 MHz system clock
   input wire logic rstn, // async reset, active low
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   input wire logic tx_change_done, // tx sequence finished normally
   input wire logic tx_change_fail, // tx sequence failed
   input wire logic [2:0] tx_change_fail_code, // cause of failure
   input wire logic tx_reset_complete, // transmitter reset done
   input wire logic rx_locked, // receiver locked
   input wire logic [1:0] rx_mode, // sd, hd or 3g
   input wire logic rx_level_b, // 3g level b
   input wire logic [3:0] rx_format, // transport format
   input wire logic [3:0] rx_frame_rate, // transport frame rate
   input wire logic rx_bit_rate, // 1/1.001 rate when high
   input wire logic rx_payload_valid, // payload packet valid
   input wire logic [31:0] rx_payload, // byte 1 in the top lane
   input wire logic rx_crc_err_tgl, // flips once per crc error
   input wire logic rx_edh_err_tgl, // flips once per edh error
   input wire logic [9:0] rx_data, // received video word
   input wire logic rx_ce, // received word valid
   input wire logic rx_eav, // end of active video marker
   output logic bidir_tx_sel, // shared interface transmits when high
   output logic rx_enable, // receiver enable
   output logic channel_pll_reset, // channel pll reset
   output logic tx_unit_reset, // transmitter reset
   output logic [1:0] tx_mode, // transmit mode to generator
   output logic [1:0] pattern_code, // pattern to generator
   output logic irq // level interrupt
);
   localparam int CAP_DEPTH = 1 << CAP_AW;
   localparam logic [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};
   localparam logic [CAP_AW:0] CAP_FULL = CAP_DEPTH[CAP_AW:0];

   function automatic logic [1:0] sig_type(input logic [1:0] mode, input logic lvl_b);
      if (mode == MODE_SD) begin
         sig_type = TYPE_SD;
      end else if (mode == MODE_HD) begin
         sig_type = TYPE_HD;
      end else begin
         sig_type = lvl_b ? TYPE_3GB : TYPE_3GA;
      end
   endfunction

   function automatic logic [1:0] pick_pattern(input logic [1:0] mode, input logic [1:0] sel);
      if (sel[0]) begin
         pick_pattern = PAT_CHECKFIELD;
      end else if (mode == MODE_SD) begin
         pick_pattern = PAT_SD_BARS;
      end else begin
         pick_pattern = sel[1] ? PAT_BARS75 : PAT_REF_BARS;
      end
   endfunction

   // synchronisers: multi-bit fields are quasi-static, sampled per bit
   logic [SYNC_W-1:0] async_in;
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   assign async_in = {tx_change_done, tx_change_fail, tx_change_fail_code, tx_reset_complete,
                      rx_locked, rx_mode, rx_level_b, rx_format, rx_frame_rate, rx_bit_rate,
                      rx_payload_valid, rx_payload, rx_crc_err_tgl, rx_edh_err_tgl,
                      rx_data, rx_ce, rx_eav};
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= async_in[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   logic s_done, s_fail, s_rstc, s_lock, s_lvlb, s_brate, s_pv, s_crc, s_edh, s_ce, s_eav;
   logic [2:0] s_code;
   logic [1:0] s_mode;
   logic [3:0] s_fmt, s_rate;
   logic [31:0] s_pay;
   logic [9:0] s_data;
   assign {s_done, s_fail, s_code, s_rstc, s_lock, s_mode, s_lvlb, s_fmt, s_rate, s_brate,
           s_pv, s_pay, s_crc, s_edh, s_data, s_ce, s_eav} = sync2_r;

   // previous values for edge detection, read from the second stage only
   logic done_d_r, fail_d_r, lock_d_r, brate_d_r, crc_d_r, edh_d_r;
   logic [1:0] mode_d_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         done_d_r <= 1'b0;
         fail_d_r <= 1'b0;
         lock_d_r <= 1'b0;
         brate_d_r <= 1'b0;
         crc_d_r <= 1'b0;
         edh_d_r <= 1'b0;
         mode_d_r <= MODE_SD;
      end else begin
         done_d_r <= s_done;
         fail_d_r <= s_fail;
         lock_d_r <= s_lock;
         brate_d_r <= s_brate;
         crc_d_r <= s_crc;
         edh_d_r <= s_edh;
         mode_d_r <= s_mode;
      end
   end
   logic done_evt, fail_evt, lock_evt, crc_evt, edh_evt, rate_chg;
   assign done_evt = s_done & ~done_d_r;
   assign fail_evt = s_fail & ~fail_d_r;
   assign lock_evt = s_lock ^ lock_d_r;
   assign crc_evt = s_crc ^ crc_d_r;
   assign edh_evt = s_edh ^ edh_d_r;
   assign rate_chg = (s_brate ^ brate_d_r) | (s_mode != mode_d_r);

   // bus slave: zero wait states, read data prepared in the address phase
   logic ap_valid, dp_wr_r, wr_en;
   logic [7:0] dp_addr_r;
   logic [31:0] rd_mux;
   assign ap_valid = hsel & htrans[1] & hready;
   assign wr_en = dp_wr_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         dp_wr_r <= 1'b0;
         dp_addr_r <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         dp_wr_r <= ap_valid & hwrite;
         dp_addr_r <= haddr[ADDR_W-1:0];
         hrdata <= (ap_valid & ~hwrite) ? rd_mux : 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // control register; reset requests and error clear are pulses
   logic [CTRL_W-1:0] ctrl_r;
   logic full_req, plain_req, clr_req;
   assign full_req = wr_en & (dp_addr_r == ADDR_CTRL) & hwdata[CTRL_FULL_RST];
   assign plain_req = wr_en & (dp_addr_r == ADDR_CTRL) & hwdata[CTRL_TX_RST];
   assign clr_req = wr_en & (dp_addr_r == ADDR_CTRL) & hwdata[CTRL_ERR_CLR];
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= CTRL_RESET;
      end else if (wr_en && dp_addr_r == ADDR_CTRL) begin
         ctrl_r <= hwdata[CTRL_W-1:0] & CTRL_KEEP_MASK;
      end
   end

   // generator and direction outputs
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         bidir_tx_sel <= 1'b0;
         rx_enable <= 1'b0;
         tx_mode <= MODE_SD;
         pattern_code <= PAT_SD_BARS;
      end else begin
         bidir_tx_sel <= ctrl_r[CTRL_DIR];
         rx_enable <= 1'b1;
         tx_mode <= ctrl_r[CTRL_MODE_LSB +: 2];
         pattern_code <= pick_pattern(ctrl_r[CTRL_MODE_LSB +: 2], ctrl_r[CTRL_PAT_LSB +: 2]);
      end
   end

   // reset pulses: a full request also holds the pll, a plain one leaves it alone
   logic [7:0] rst_cnt_r;
   logic pll_hold_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_cnt_r <= 8'h00;
         pll_hold_r <= 1'b0;
         channel_pll_reset <= 1'b0;
         tx_unit_reset <= 1'b0;
      end else begin
         if (full_req || plain_req) begin
            rst_cnt_r <= 8'(RST_PULSE_CYC);
            pll_hold_r <= full_req | (pll_hold_r & (rst_cnt_r != 8'h00));
         end else if (rst_cnt_r != 8'h00) begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
         end else begin
            pll_hold_r <= 1'b0;
         end
         tx_unit_reset <= full_req | plain_req | (rst_cnt_r > 8'h01);
         channel_pll_reset <= full_req | (pll_hold_r & (rst_cnt_r > 8'h01));
      end
   end

   // tx sequence result; a new reset request starts a new sequence
   logic tx_done_r, tx_fail_r;
   logic [2:0] tx_code_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tx_done_r <= 1'b0;
         tx_fail_r <= 1'b0;
         tx_code_r <= 3'h0;
      end else if (fail_evt) begin
         tx_fail_r <= 1'b1;
         tx_done_r <= 1'b0;
         tx_code_r <= s_code;
      end else if (done_evt) begin
         tx_done_r <= 1'b1;
         tx_fail_r <= 1'b0;
         tx_code_r <= 3'h0;
      end else if (full_req || plain_req) begin
         tx_done_r <= 1'b0;
         tx_fail_r <= 1'b0;
      end
   end

   // sticky error flag and saturating counter
   logic err_flag_r;
   logic [CNT_W-1:0] err_cnt_r;
   logic cnt_evt;
   assign cnt_evt = (s_mode == MODE_SD) ? edh_evt : crc_evt;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         err_flag_r <= 1'b0;
      end else if (crc_evt || edh_evt) begin
         err_flag_r <= 1'b1;
      end else if (clr_req) begin
         err_flag_r <= 1'b0;
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         err_cnt_r <= '0;
      end else if (clr_req || rate_chg) begin
         err_cnt_r <= '0;
      end else if (cnt_evt && err_cnt_r != CNT_MAX) begin
         err_cnt_r <= err_cnt_r + 1'b1;
      end
   end

   // receive status snapshot; fields are transport values passed as detected
   logic [31:0] rx_stat_r;
   logic [31:0] pay_r;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rx_stat_r <= 32'h0000_0000;
         pay_r <= 32'h0000_0000;
      end else begin
         rx_stat_r <= 32'h0000_0000;
         rx_stat_r[RXS_LOCK] <= s_lock;
         rx_stat_r[RXS_TYPE_LSB +: 2] <= sig_type(s_mode, s_lvlb);
         rx_stat_r[RXS_FMT_LSB +: 4] <= s_fmt;
         rx_stat_r[RXS_RATE_LSB +: 4] <= s_rate;
         rx_stat_r[RXS_BITRATE] <= s_brate;
         rx_stat_r[RXS_PV] <= s_pv;
         rx_stat_r[RXS_ERR] <= err_flag_r;
         pay_r <= s_pay;
      end
   end

   // capture buffer
   scc_cap_state_type cap_st_r;
   logic [9:0] cap_mem [CAP_DEPTH];
   logic [CAP_AW:0] cap_cnt_r;
   logic [CAP_AW-1:0] cap_idx_r;
   logic cap_done_r, cap_arm_req, cap_fin;
   assign cap_arm_req = wr_en & (dp_addr_r == ADDR_CAP_CTRL) & hwdata[CAP_ARM];
   assign cap_fin = (cap_st_r == CAP_STORE) & s_ce & (cap_cnt_r == CAP_FULL - 1'b1);
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cap_st_r <= CAP_IDLE;
         cap_cnt_r <= '0;
         cap_done_r <= 1'b0;
      end else begin
         case (cap_st_r)
            CAP_IDLE: begin
               if (cap_arm_req) begin
                  cap_st_r <= CAP_WAIT_EAV;
                  cap_cnt_r <= '0;
                  cap_done_r <= 1'b0;
               end
            end
            CAP_WAIT_EAV: begin
               if (s_eav) begin
                  cap_st_r <= CAP_STORE;
               end
            end
            CAP_STORE: begin
               if (s_ce) begin
                  cap_cnt_r <= cap_cnt_r + 1'b1;
               end
               if (cap_fin) begin
                  cap_st_r <= CAP_IDLE;
                  cap_done_r <= 1'b1;
               end
            end
            default: begin
               cap_st_r <= CAP_IDLE;
            end
         endcase
      end
   end
   // no reset on the array so it maps onto plain memory
   always_ff @(posedge sys_clk) begin
      if (cap_st_r == CAP_STORE && s_ce) begin
         cap_mem[cap_cnt_r[CAP_AW-1:0]] <= s_data;
      end
   end
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cap_idx_r <= '0;
      end else if (wr_en && dp_addr_r == ADDR_CAP_CTRL) begin
         cap_idx_r <= hwdata[CAP_IDX_LSB +: CAP_AW];
      end
   end

   // interrupts: set wins over a same-cycle write-one clear
   logic [IRQ_W-1:0] irq_stat_r, irq_mask_r, irq_set;
   assign irq_set = {cap_fin, lock_evt, crc_evt | edh_evt, fail_evt, done_evt};
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_r <= '0;
         irq_mask_r <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_en && dp_addr_r == ADDR_IRQ_STAT) begin
            irq_stat_r <= (irq_stat_r & ~hwdata[IRQ_W-1:0]) | irq_set;
         end else begin
            irq_stat_r <= irq_stat_r | irq_set;
         end
         if (wr_en && dp_addr_r == ADDR_IRQ_MASK) begin
            irq_mask_r <= hwdata[IRQ_W-1:0];
         end
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      case (haddr[ADDR_W-1:0])
         ADDR_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
         ADDR_TX_STAT: begin
            rd_mux[TXS_DONE] = tx_done_r;
            rd_mux[TXS_FAIL] = tx_fail_r;
            rd_mux[TXS_CODE_LSB +: 3] = tx_code_r;
            rd_mux[TXS_RSTDONE] = s_rstc;
         end
         ADDR_RX_STAT: rd_mux = rx_stat_r;
         ADDR_PAYLOAD: rd_mux = pay_r;
         ADDR_ERR_CNT: rd_mux[CNT_W-1:0] = err_cnt_r;
         ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_r;
         ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
         ADDR_CAP_CTRL: begin
            rd_mux[CAP_ARM] = (cap_st_r != CAP_IDLE);
            rd_mux[CAP_DONE] = cap_done_r;
            rd_mux[CAP_CNT_LSB +: CAP_FLD_W] = CAP_FLD_W'(cap_cnt_r);
            rd_mux[CAP_IDX_LSB +: CAP_FLD_W] = CAP_FLD_W'(cap_idx_r);
         end
         ADDR_CAP_DATA: rd_mux[9:0] = cap_mem[cap_idx_r];
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   chk_fail_code: assert property (@(posedge sys_clk) disable iff (!rstn)
      fail_evt |=> tx_fail_r && !tx_done_r && tx_code_r == $past(s_code)) else $error("fail code not latched");
   chk_done_show: assert property (@(posedge sys_clk) disable iff (!rstn)
      (done_evt && !fail_evt) |=> tx_done_r && !tx_fail_r) else $error("done not shown");
   chk_pattern_sd: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ctrl_r[CTRL_MODE_LSB +: 2] == MODE_SD && !ctrl_r[CTRL_PAT_LSB]) |=> pattern_code == PAT_SD_BARS)
      else $error("sd pattern wrong");
   chk_pattern_hd: assert property (@(posedge sys_clk) disable iff (!rstn)
      (ctrl_r[CTRL_MODE_LSB +: 2] != MODE_SD && ctrl_r[CTRL_PAT_LSB +: 2] == 2'h2) |=> pattern_code == PAT_BARS75)
      else $error("hd pattern wrong");
   chk_dir_follow: assert property (@(posedge sys_clk) disable iff (!rstn)
      ##1 bidir_tx_sel == $past(ctrl_r[CTRL_DIR])) else $error("direction not followed");
   chk_rx_enabled: assert property (@(posedge sys_clk) disable iff (!rstn)
      bidir_tx_sel |-> rx_enable) else $error("receiver off while transmitting");
   chk_full_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
      full_req |=> (channel_pll_reset && tx_unit_reset) [*8]) else $error("full reset too short");
   chk_plain_reset: assert property (@(posedge sys_clk) disable iff (!rstn)
      (plain_req && !full_req && !pll_hold_r) |=> tx_unit_reset && !channel_pll_reset)
      else $error("plain reset touched pll");
   chk_lock_status: assert property (@(posedge sys_clk) disable iff (!rstn)
      ##1 rx_stat_r[RXS_LOCK] == $past(s_lock)) else $error("lock status wrong");
   chk_err_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
      (err_flag_r && !clr_req) |=> err_flag_r) else $error("error flag dropped");
   chk_err_count: assert property (@(posedge sys_clk) disable iff (!rstn)
      (crc_evt && !edh_evt && s_mode == MODE_SD && !clr_req && !rate_chg) |=> $stable(err_cnt_r))
      else $error("crc counted in sd");
   chk_rate_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      (rate_chg || clr_req) |=> err_cnt_r == '0) else $error("count not cleared");
   chk_cnt_sat: assert property (@(posedge sys_clk) disable iff (!rstn)
      (err_cnt_r == CNT_MAX && !clr_req && !rate_chg) |=> err_cnt_r == CNT_MAX) else $error("counter wrapped");
   chk_cap_qual: assert property (@(posedge sys_clk) disable iff (!rstn)
      (cap_st_r != CAP_STORE || !s_ce) && !cap_arm_req |=> $stable(cap_cnt_r)) else $error("stored without ce");
endmodule // scc_channel_ctrl
`default_nettype wire

// [logic/scc_pkg.sv]
// shared constants, register map and types of the channel control and status block
//
// Function
// - after each transmitter start-up or change sequence the block shows done on success, or fail plus a cause code.
// - cause code 1 is PLL not locked, 2 and 3 reset-done not negated or not asserted, 4 rate change not acknowledged, 5 and 6 reset failure during clock-select change.
// - in HD and 3G modes pattern select 0 gives reference bars, 1 and 3 the checkfield, 2 the 75% bars.
// - in SD mode pattern select 0 and 2 give SD bars, 1 and 3 the checkfield.
// - on a bidirectional channel direction 1 means transmit and 0 means receive.
// - the receiver stays enabled while a bidirectional channel transmits, to see the loopback.
// - a full transmitter reset resets the channel PLL and the transmitter, a plain one the transmitter only.
// - the locked status is high while the receiver is locked and low otherwise.
// - signal type is reported as SD, HD, 3G level A or 3G level B, with no split of the level B variants.
// - format and frame rate report the transport structure, not the picture format.
// - the four payload identifier bytes, byte 1 to byte 4, are always shown, and flagged valid only while the packet is valid.
// - any CRC or EDH error sets a sticky error flag that holds until a clear request.
// - CRC errors are counted in HD and 3G, EDH errors in SD only, and a clear request zeroes the count.
// - the error count also clears when the input changes bit rate, early in relock.
// - receive capture triggers on an end-of-active-video marker and stores only while clock enable is high.
package scc_pkg;
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned RST_PULSE_NS = 64;
   localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned SYNC_W = 66;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_TX_STAT = 8'h04;
   localparam logic [7:0] ADDR_RX_STAT = 8'h08;
   localparam logic [7:0] ADDR_PAYLOAD = 8'h0C;
   localparam logic [7:0] ADDR_ERR_CNT = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
   localparam logic [7:0] ADDR_CAP_CTRL = 8'h1C;
   localparam logic [7:0] ADDR_CAP_DATA = 8'h20;
   // control register fields
   localparam int unsigned CTRL_DIR = 0;
   localparam int unsigned CTRL_FULL_RST = 1;
   localparam int unsigned CTRL_TX_RST = 2;
   localparam int unsigned CTRL_ERR_CLR = 3;
   localparam int unsigned CTRL_PAT_LSB = 4;
   localparam int unsigned CTRL_MODE_LSB = 6;
   localparam int unsigned CTRL_W = 8;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] CTRL_KEEP_MASK = 8'hF1;
   // tx status fields
   localparam int unsigned TXS_DONE = 0;
   localparam int unsigned TXS_FAIL = 1;
   localparam int unsigned TXS_CODE_LSB = 2;
   localparam int unsigned TXS_RSTDONE = 5;
   // rx status fields
   localparam int unsigned RXS_LOCK = 0;
   localparam int unsigned RXS_TYPE_LSB = 1;
   localparam int unsigned RXS_FMT_LSB = 3;
   localparam int unsigned RXS_RATE_LSB = 7;
   localparam int unsigned RXS_BITRATE = 11;
   localparam int unsigned RXS_PV = 12;
   localparam int unsigned RXS_ERR = 13;
   // capture control fields
   localparam int unsigned CAP_ARM = 0;
   localparam int unsigned CAP_DONE = 1;
   localparam int unsigned CAP_CNT_LSB = 8;
   localparam int unsigned CAP_IDX_LSB = 16;
   localparam int unsigned CAP_FLD_W = 8;
   // interrupt bits
   localparam int unsigned IRQ_TX_DONE = 0;
   localparam int unsigned IRQ_TX_FAIL = 1;
   localparam int unsigned IRQ_RX_ERR = 2;
   localparam int unsigned IRQ_LOCK_CHG = 3;
   localparam int unsigned IRQ_CAP_DONE = 4;
   localparam int unsigned IRQ_W = 5;
   // transport modes
   localparam logic [1:0] MODE_SD = 2'h0;
   localparam logic [1:0] MODE_HD = 2'h1;
   localparam logic [1:0] MODE_3G = 2'h2;
   // reported signal types
   localparam logic [1:0] TYPE_SD = 2'h0;
   localparam logic [1:0] TYPE_HD = 2'h1;
   localparam logic [1:0] TYPE_3GA = 2'h2;
   localparam logic [1:0] TYPE_3GB = 2'h3;
   // pattern generator codes
   localparam logic [1:0] PAT_REF_BARS = 2'h0;
   localparam logic [1:0] PAT_CHECKFIELD = 2'h1;
   localparam logic [1:0] PAT_BARS75 = 2'h2;
   localparam logic [1:0] PAT_SD_BARS = 2'h3;
   // failure causes
   localparam logic [2:0] FAIL_PLL_LOCK = 3'h1;
   localparam logic [2:0] FAIL_RST_NEG = 3'h2;
   localparam logic [2:0] FAIL_RST_ASSERT = 3'h3;
   localparam logic [2:0] FAIL_RATE_ACK = 3'h4;
   localparam logic [2:0] FAIL_SEL_NEG = 3'h5;
   localparam logic [2:0] FAIL_SEL_ASSERT = 3'h6;
   typedef enum logic [2:0] {
      CAP_IDLE = 3'b001,
      CAP_WAIT_EAV = 3'b010,
      CAP_STORE = 3'b100
   } scc_cap_state_type;
endpackage

// [sim/scc_far_model.sv]
// far-side model: transmitter feedback, error events and a stream of received words
`timescale 1ns/1ps
`default_nettype none
module scc_far_model (
   input wire logic sys_clk, // clock
   input wire logic tx_unit_reset, // transmitter reset
   output logic tx_change_done, // done level
   output logic tx_change_fail, // fail level
   output logic [2:0] tx_change_fail_code, // cause
   output logic tx_reset_complete, // reset done
   output logic rx_crc_err_tgl, // crc event
   output logic rx_edh_err_tgl, // edh event
   output logic [9:0] rx_data, // video word
   output logic rx_ce, // word valid
   output logic rx_eav // eav marker
);
   logic [8:0] ph_r = 9'h0;
   initial {tx_change_done, tx_change_fail, tx_change_fail_code, tx_reset_complete, rx_crc_err_tgl,
            rx_edh_err_tgl, rx_data, rx_ce, rx_eav} = '0;
   // each word held 4 cycles so the input synchronisers never miss one
   always @(posedge sys_clk) begin
      ph_r <= ph_r + 9'h1;
      {rx_eav, rx_ce, rx_data} <= {ph_r[8:2] == 7'h7F, ph_r[2], 3'h0, ph_r[8:2]};
      tx_reset_complete <= !tx_unit_reset;
   end
   task automatic result(input logic fail, input logic [2:0] code);
      tx_change_fail_code <= code;
      repeat (4) @(posedge sys_clk);
      tx_change_fail <= fail;
      tx_change_done <= !fail;
      repeat (8) @(posedge sys_clk);
      {tx_change_done, tx_change_fail} <= 2'h0;
      repeat (4) @(posedge sys_clk);
   endtask
   task automatic err(input logic crc);
      if (crc) rx_crc_err_tgl <= !rx_crc_err_tgl;
      else rx_edh_err_tgl <= !rx_edh_err_tgl;
      repeat (6) @(posedge sys_clk);
   endtask
endmodule // scc_far_model
`default_nettype wire

// [sim/scc_channel_ctrl_bench.sv]
// self-checking bench of the channel control and status block
`timescale 1ns/1ps
`default_nettype none
module scc_channel_ctrl_bench import scc_pkg::*;;
   logic sys_clk, rstn, hsel, hwrite, hreadyout, hresp, rx_locked, rx_level_b, rx_bit_rate, rx_payload_valid;
   logic tx_change_done, tx_change_fail, tx_reset_complete, rx_crc_err_tgl, rx_edh_err_tgl, rx_ce, rx_eav;
   logic bidir_tx_sel, rx_enable, channel_pll_reset, tx_unit_reset, irq;
   logic [31:0] haddr, hwdata, hrdata, rx_payload, d;
   logic [1:0] htrans, rx_mode, tx_mode, pattern_code;
   logic [2:0] hsize, tx_change_fail_code;
   logic [3:0] rx_format, rx_frame_rate;
   logic [9:0] rx_data;
   wire logic hready;
   int n_fail, samples_checked, np, nt;
   assign hready = hreadyout;
   scc_channel_ctrl dut_u (.*);
   scc_far_model far_u (.*);
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
      do @(posedge sys_clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge sys_clk); while (hready !== 1'b1);
      d = hrdata;
      chk("hresp", 32'h0, 32'(hresp));
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic test_pattern();
      logic [1:0] e;
      bus(0, 8'h3C, 32'h0);
      chk("unmapped", 32'h0, d);
      for (int m = 0; m < 3; m++) begin
         for (int s = 0; s < 4; s++) begin
            e = s[0] ? PAT_CHECKFIELD : m == 0 ? PAT_SD_BARS : s[1] ? PAT_BARS75 : PAT_REF_BARS;
            bus(1, ADDR_CTRL, 32'(m * 64 + s * 16));
            repeat (2) @(posedge sys_clk);
            chk("pattern_code", 32'(e), 32'(pattern_code));
            chk("tx_mode", 32'(m), 32'(tx_mode));
         end
      end
      $display("test_pattern done");
   endtask
   task automatic test_dir_reset();
      bus(1, ADDR_CTRL, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk("bidir_tx_sel", 32'h1, 32'(bidir_tx_sel));
      chk("rx_enable", 32'h1, 32'(rx_enable));
      for (int k = 1; k < 3; k++) begin
         bus(1, ADDR_CTRL, 32'(1 << k));
         {np, nt} = '0;
         repeat (20) begin
            @(posedge sys_clk);
            np += int'(channel_pll_reset === 1'b1);
            nt += int'(tx_unit_reset === 1'b1);
         end
         chk("pll pulse", 32'(k == 1 ? RST_PULSE_CYC : 0), 32'(np));
         chk("tx pulse long", 32'h1, 32'(nt >= RST_PULSE_CYC));
      end
      chk("bidir rx", 32'h0, 32'(bidir_tx_sel));
      $display("test_dir_reset done");
   endtask
   task automatic test_tx();
      far_u.result(1'b0, 3'h0);
      bus(0, ADDR_TX_STAT, 32'h0);
      chk("done", 32'h1, 32'(d[TXS_DONE]));
      for (int c = 1; c < 7; c++) begin
         far_u.result(1'b1, 3'(c));
         bus(0, ADDR_TX_STAT, 32'h0);
         chk("fail", 32'h1, 32'(d[TXS_FAIL]));
         chk("fail_code", 32'(c), 32'(d[TXS_CODE_LSB +: 3]));
      end
      chk("reset_complete", 32'h1, 32'(d[TXS_RSTDONE]));
      chk("irq masked", 32'h0, 32'(irq));
      bus(1, ADDR_IRQ_MASK, 32'h2);
      repeat (3) @(posedge sys_clk);
      chk("irq", 32'h1, 32'(irq));
      bus(1, ADDR_IRQ_STAT, 32'h1F);
      repeat (3) @(posedge sys_clk);
      chk("irq cleared", 32'h0, 32'(irq));
      $display("test_tx done");
   endtask
   task automatic test_rx();
      {rx_locked, rx_mode, rx_level_b, rx_format, rx_frame_rate, rx_payload_valid, rx_payload} <=
         {1'b1, MODE_3G, 1'b1, 4'h5, 4'hA, 1'b1, 32'h1234_5678};
      repeat (6) @(posedge sys_clk);
      bus(0, ADDR_RX_STAT, 32'h0);
      chk("rx_stat", {19'h0, 1'b1, 1'b0, 4'hA, 4'h5, TYPE_3GB, 1'b1}, d & 32'h0000_1FFF);
      bus(0, ADDR_PAYLOAD, 32'h0);
      chk("payload", 32'h1234_5678, d);
      repeat (3) far_u.err(1'b1);
      far_u.err(1'b0);
      bus(0, ADDR_ERR_CNT, 32'h0);
      chk("crc count", 32'h3, d);
      bus(0, ADDR_RX_STAT, 32'h0);
      chk("err flag", 32'h1, 32'(d[RXS_ERR]));
      bus(1, ADDR_CTRL, 32'h8);
      repeat (4) @(posedge sys_clk);
      bus(0, ADDR_RX_STAT, 32'h0);
      chk("flag clear", 32'h0, 32'(d[RXS_ERR]));
      bus(0, ADDR_ERR_CNT, 32'h0);
      chk("count clear", 32'h0, d);
      rx_mode <= MODE_SD;
      repeat (6) @(posedge sys_clk);
      repeat (2) far_u.err(1'b0);
      far_u.err(1'b1);
      bus(0, ADDR_ERR_CNT, 32'h0);
      chk("edh count", 32'h2, d);
      rx_bit_rate <= 1'b1;
      repeat (6) @(posedge sys_clk);
      bus(0, ADDR_ERR_CNT, 32'h0);
      chk("rate clear", 32'h0, d);
      bus(1, ADDR_CAP_CTRL, 32'h1);
      repeat (800) @(posedge sys_clk);
      bus(0, ADDR_CAP_CTRL, 32'h0);
      chk("capture", 32'h4002, d & 32'hFF03);
      $display("test_rx done");
   endtask
   initial begin
      {rstn, hsel, haddr, htrans, hwrite, hwdata, rx_locked, rx_mode, rx_level_b, rx_format} = '0;
      {rx_frame_rate, rx_bit_rate, rx_payload_valid, rx_payload, n_fail, samples_checked} = '0;
      hsize = 3'h2;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      @(posedge sys_clk);
      test_pattern();
      test_dir_reset();
      test_tx();
      test_rx();
      finish_test();
   end
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
endmodule // scc_channel_ctrl_bench
`default_nettype wire
